// [core/fiec_pkg.sv]
// Constants, types and carriers of the float/integer/exponent conversion datapath
`default_nettype none
package fiec_pkg;
    // ********************************************************************
    // Exponent constants, excess-200 (octal) notation
    // ********************************************************************
    localparam logic [7:0]  EXP_BIAS       = 8'h80;   // 200 octal
    localparam logic [7:0]  EXP_BIAS_NEG   = 8'h80;   // Two's complement of 200 octal
    localparam logic [15:0] LOAD_EXPONENT_OP_ZERO     = 16'hFF80; // 177600 octal, unbiased -200 octal, which biases to a zero exponent
    localparam logic [7:0]  EXP_SHORT_INIT = 8'h8F;   // 217 octal
    localparam logic [7:0]  EXP_LONG_INIT  = 8'h9F;   // 237 octal
    localparam logic [8:0]  EXP_F2I_BASE   = 9'h081;  // 201 octal
    localparam logic [8:0]  RANGE_SHORT    = 9'h010;  // 20 octal
    localparam logic [8:0]  RANGE_LONG     = 9'h020;  // 40 octal

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int FRAC_W   = 56;
    localparam int ACC_W    = 64;
    localparam int HI9_LSB  = 7;   // Low bit of the nine high-order exponent bits
    localparam int SGL_BITS = 24;

    // ********************************************************************
    // Operations, variants, states, exception codes
    // ********************************************************************
    typedef enum logic [1:0] {
        load_exponent_op  = 2'h0,
        load_integer_op   = 2'h1,
        store_exponent_op = 2'h2,
        store_integer_op  = 2'h3
    } fiec_op_t;

    typedef enum logic [1:0] {
        single_to_short_op = 2'h0,
        single_to_long_op  = 2'h1,
        double_to_short_op = 2'h2,
        double_to_long_op  = 2'h3
    } fiec_variant_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_NORM = 4'h2,
        S_RSH  = 4'h4,
        S_FIN  = 4'h8
    } fiec_state_t;

    typedef enum logic [2:0] {
        EXC_NONE      = 3'h0,
        EXC_CONV_FRAC = 3'h1,
        EXC_CONV_RNG  = 3'h2,
        EXC_CONV_SIGN = 3'h3,
        EXC_EXP_OVF   = 3'h4,
        EXC_EXP_UNF   = 3'h5
    } fiec_exc_t;

    typedef struct packed {
        logic              sign;
        logic [7:0]        exp;
        logic [FRAC_W-1:0] frac;  // Bit 55 is the leading fraction bit
    } fiec_float_t;
endpackage : fiec_pkg
`default_nettype wire

// [core/fiec_exp_unit.sv]
// Exponent legality check for load-exponent and excess removal for store-exponent
`default_nettype none
module fiec_exp_unit
    import fiec_pkg::*;
(
    input  wire logic [15:0] ld_src,
    input  wire logic [7:0]  st_exp,
    output logic      [7:0]  ld_exp,
    output logic             ld_over,
    output logic             ld_under,
    output logic      [15:0] st_word
);
    logic       legal;
    logic [7:0] unbiased;

    // Legal only when the nine high bits agree; -200 octal, which biases to zero, is an underflow
    assign legal    = (&ld_src[15:HI9_LSB]) | ~(|ld_src[15:HI9_LSB]);
    assign ld_over  = ~legal & ~ld_src[15];
    assign ld_under = (~legal & ld_src[15]) | (ld_src == LOAD_EXPONENT_OP_ZERO);
    assign ld_exp   = ld_src[7:0] + EXP_BIAS;

    // Subtract by adding the complement, then sign-extend bit 7
    assign unbiased = st_exp + EXP_BIAS_NEG;
    assign st_word  = {{8{unbiased[7]}}, unbiased};
endmodule // fiec_exp_unit
`default_nettype wire

// [core/float_int_exponent_convert.sv]
// Conversion datapath: load/store exponent and integer/float conversions
`default_nettype none
module float_int_exponent_convert
    import fiec_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire fiec_op_t    op_code,
    input  wire logic [31:0] src_int,
    input  wire fiec_float_t src_float,
    input  wire logic        double_precision_flag,
    input  wire logic        long_integer_flag,
    input  wire logic        conversion_trap_enable,
    output logic             busy,
    output logic             res_valid,
    output fiec_float_t      res_float,
    output logic      [31:0] res_int,
    output logic             zero_condition_flag,
    output logic             conversion_error,
    output logic             exp_overflow,
    output logic             exp_underflow,
    output logic             conversion_trap,
    output fiec_exc_t        exc_code
);
    // ********************************************************************
    // Working state
    // ********************************************************************
    fiec_state_t      state;
    fiec_op_t         op_r;
    fiec_variant_t    variant;
    logic [ACC_W-1:0] acc;
    logic [7:0]       exp_w;
    logic [31:0]      work;
    logic [7:0]       cnt;
    logic             sign_r;
    logic             dbl_r;
    logic             lng_r;
    logic             trap_en_r;

    logic             take;
    logic [7:0]       ld_exp;
    logic             ld_over;
    logic             ld_under;
    logic [15:0]      st_word;
    logic [ACC_W-1:0] li_raw;
    logic [ACC_W-1:0] li_mag;
    logic [8:0]       diff1;
    logic [8:0]       diff2;
    logic [8:0]       range;
    logic [7:0]       shifts;
    logic             norm_done;
    logic [31:0]      ival;
    logic             ival_msb;

    assign take    = op_valid & (state == S_IDLE);
    assign variant = fiec_variant_t'({double_precision_flag, long_integer_flag});

    fiec_exp_unit u_exp (
        .ld_src   (src_int[15:0]),
        .st_exp   (src_float.exp),
        .ld_exp   (ld_exp),
        .ld_over  (ld_over),
        .ld_under (ld_under),
        .st_word  (st_word)
    );

    // ********************************************************************
    // Integer-to-float setup
    // ********************************************************************
    // Placing at 63-48 or 63-32 lands the integer at the top of the accumulator directly
    assign li_raw = long_integer_flag ? {src_int, 32'h0}
                                      : {src_int[15:0], 48'h0};
    assign li_mag = li_raw[ACC_W-1] ? (~li_raw + 64'h1) : li_raw;

    // Done once bit 62 leads; a zero integer never normalizes and stops at once
    assign norm_done = ~acc[ACC_W-1] & (acc[ACC_W-2] | (acc == 64'h0));

    // ********************************************************************
    // Float-to-integer tests
    // ********************************************************************
    assign range  = long_integer_flag ? RANGE_LONG : RANGE_SHORT;
    assign diff1  = {1'b0, src_float.exp} - EXP_F2I_BASE;
    assign diff2  = diff1 - range;
    assign shifts = 8'(range + EXP_F2I_BASE - {1'b0, src_float.exp} - 9'h001);

    // Complement negative results; the MSB is then checked against the sign
    assign ival     = sign_r ? (~work + 32'h1) : work;
    assign ival_msb = lng_r ? ival[31] : ival[15];

    // ********************************************************************
    // Sequencer and datapath
    // ********************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= S_IDLE;
            op_r      <= load_exponent_op;
            acc       <= 64'h0;
            exp_w     <= 8'h00;
            work      <= 32'h0;
            cnt       <= 8'h00;
            sign_r    <= 1'b0;
            dbl_r     <= 1'b0;
            lng_r     <= 1'b0;
            trap_en_r <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (take) begin
                        op_r      <= op_code;
                        dbl_r     <= double_precision_flag;
                        lng_r     <= long_integer_flag;
                        trap_en_r <= conversion_trap_enable;
                        sign_r    <= src_float.sign;
                        if (op_code == load_integer_op) begin
                            acc    <= li_mag;
                            sign_r <= li_raw[ACC_W-1];
                            exp_w  <= long_integer_flag ? EXP_LONG_INIT
                                                        : EXP_SHORT_INIT;
                            state  <= S_NORM;
                        end else if (op_code == store_integer_op && !diff1[8] && diff2[8]) begin
                            // The most negative integer still converts; a bad value fails the sign check
                            // Single to long takes the whole 24-bit fraction only
                            work  <= (variant == single_to_long_op)
                                   ? {src_float.frac[FRAC_W-1 -: SGL_BITS], 8'h00}
                                   : long_integer_flag ? src_float.frac[FRAC_W-1 -: 32]
                                   : {16'h0, src_float.frac[FRAC_W-1 -: 16]};
                            cnt   <= shifts;
                            state <= S_RSH;
                        end
                    end
                end
                S_NORM: begin
                    if (acc[ACC_W-1]) begin
                        // Only the most negative integer stays set after complement
                        acc   <= acc >> 1;
                        exp_w <= exp_w + 8'h01;
                    end else if (norm_done) begin
                        state <= S_IDLE;
                    end else begin
                        acc   <= acc << 1;
                        exp_w <= exp_w - 8'h01;
                    end
                end
                S_RSH: begin
                    // Bits falling off the right are dropped, so rounding never happens
                    if (cnt == 8'h00) begin
                        state <= S_FIN;
                    end else begin
                        work <= work >> 1;
                        cnt  <= cnt - 8'h01;
                    end
                end
                S_FIN: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ********************************************************************
    // Results, flags and exception codes
    // ********************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy                <= 1'b0;
            res_valid           <= 1'b0;
            res_float           <= '0;
            res_int             <= 32'h0;
            zero_condition_flag <= 1'b0;
            conversion_error    <= 1'b0;
            exp_overflow        <= 1'b0;
            exp_underflow       <= 1'b0;
            conversion_trap     <= 1'b0;
            exc_code            <= EXC_NONE;
        end else begin
            res_valid <= 1'b0;
            if (take) begin
                conversion_error <= 1'b0;
                exp_overflow     <= 1'b0;
                exp_underflow    <= 1'b0;
                conversion_trap  <= 1'b0;
                exc_code         <= EXC_NONE;
                busy             <= 1'b0;
                case (op_code)
                    load_exponent_op: begin
                        res_valid     <= 1'b1;
                        res_float     <= '{sign: src_float.sign, exp: ld_exp,
                                           frac: src_float.frac};
                        exp_overflow  <= ld_over;
                        exp_underflow <= ld_under;
                        exc_code      <= ld_over  ? EXC_EXP_OVF :
                                         ld_under ? EXC_EXP_UNF : EXC_NONE;
                    end
                    store_exponent_op: begin
                        res_valid <= 1'b1;
                        res_int   <= {16'h0, st_word};
                    end
                    load_integer_op: begin
                        busy <= 1'b1;
                    end
                    store_integer_op: begin
                        if (diff1[8] || !diff2[8]) begin
                            // Fraction or out of range: zeros out, error raised
                            res_valid           <= 1'b1;
                            res_int             <= 32'h0;
                            conversion_error    <= 1'b1;
                            conversion_trap     <= conversion_trap_enable;
                            zero_condition_flag <= diff1[8];
                            exc_code            <= diff1[8] ? EXC_CONV_FRAC
                                                            : EXC_CONV_RNG;
                        end else begin
                            busy <= 1'b1;
                        end
                    end
                    default: begin
                        res_valid <= 1'b0;
                    end
                endcase
            end else if (state == S_NORM && norm_done) begin
                busy                <= 1'b0;
                res_valid           <= 1'b1;
                zero_condition_flag <= (acc == 64'h0);
                res_float.sign      <= sign_r & (acc != 64'h0);
                res_float.exp       <= (acc == 64'h0) ? 8'h00 : exp_w;
                // Single keeps 24 bits; the rest are cut, not rounded
                res_float.frac      <= dbl_r ? acc[ACC_W-2 -: FRAC_W]
                                             : {acc[ACC_W-2 -: SGL_BITS],
                                                32'h0};
            end else if (state == S_FIN) begin
                busy                <= 1'b0;
                res_valid           <= 1'b1;
                res_int             <= lng_r ? ival : {16'h0, ival[15:0]};
                zero_condition_flag <= 1'b0;
                conversion_error    <= (ival_msb != sign_r);
                conversion_trap     <= (ival_msb != sign_r) & trap_en_r;
                exc_code            <= (ival_msb != sign_r) ? EXC_CONV_SIGN
                                                            : EXC_NONE;
            end
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    property p_load_exponent_op_zero;
        @(posedge mclk) disable iff (!rst_n)
        take && op_code == load_exponent_op && src_int[15:0] == LOAD_EXPONENT_OP_ZERO
            |=> res_valid && exp_underflow && exc_code == EXC_EXP_UNF;
    endproperty
    a_load_exponent_op_zero: assert property (p_load_exponent_op_zero) else $error("zero exponent not underflow");

    property p_store_exponent_op;
        @(posedge mclk) disable iff (!rst_n)
        take && op_code == store_exponent_op
            |=> res_int[7:0] == $past(src_float.exp) + 8'h80 && res_int[15:8] == {8{res_int[7]}};
    endproperty
    a_store_exponent_op: assert property (p_store_exponent_op) else $error("store exponent value wrong");

    property p_norm;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && op_r == load_integer_op && !zero_condition_flag |-> res_float.frac[55];
    endproperty
    a_norm: assert property (p_norm) else $error("loaded integer not normalized");

    property p_trunc;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && op_r == load_integer_op && !dbl_r |-> res_float.frac[31:0] == 32'h0;
    endproperty
    a_trunc: assert property (p_trunc) else $error("single result has low bits");

    property p_frac_err;
        @(posedge mclk) disable iff (!rst_n)
        take && op_code == store_integer_op && src_float.exp < 8'h81
            |=> res_valid && conversion_error && zero_condition_flag && res_int == 32'h0;
    endproperty
    a_frac_err: assert property (p_frac_err) else $error("fraction test missed");

    property p_range_err;
        @(posedge mclk) disable iff (!rst_n)
        take && op_code == store_integer_op
            && src_float.exp >= (long_integer_flag ? 8'hA1 : 8'h91)
            |=> res_valid && conversion_error && res_int == 32'h0;
    endproperty
    a_range_err: assert property (p_range_err) else $error("range test missed");

    property p_sign_ok;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && op_r == store_integer_op && !conversion_error
            |-> (lng_r ? res_int[31] : res_int[15]) == sign_r;
    endproperty
    a_sign_ok: assert property (p_sign_ok) else $error("integer sign mismatch");

    property p_trap;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && conversion_error |-> conversion_trap == trap_en_r;
    endproperty
    a_trap: assert property (p_trap) else $error("trap does not follow enable");

    property p_f2i_bound;
        @(posedge mclk) disable iff (!rst_n)
        take && op_code == store_integer_op |-> ##[1:40] res_valid;
    endproperty
    a_f2i_bound: assert property (p_f2i_bound) else $error("conversion never ended");

    property p_li_bound;
        @(posedge mclk) disable iff (!rst_n)
        take && op_code == load_integer_op |-> ##[2:70] res_valid;
    endproperty
    a_li_bound: assert property (p_li_bound) else $error("normalize never ended");
endmodule // float_int_exponent_convert
`default_nettype wire

// [dv/fiec_host_model.sv]
// Host processor model that hands operations and operands to the datapath
`default_nettype none
module fiec_host_model
    import fiec_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  res_valid,
    output logic       op_valid,
    output fiec_op_t   op_code,
    output logic [31:0] src_int,
    output fiec_float_t src_float,
    output logic       double_precision_flag,
    output logic       long_integer_flag,
    output logic       conversion_trap_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Request issue
    // ****************************************************************
    initial begin
        op_valid = 1'b0;
        op_code = load_exponent_op;
        src_int = 32'h0;
        src_float = '0;
        {double_precision_flag, long_integer_flag, conversion_trap_enable} = 3'h0;
    end

    // Operands are inverted once taken, so a late sample shows up as a wrong result
    task automatic issue(input fiec_op_t op, input logic [31:0] si, input fiec_float_t sf,
                         input logic [2:0] md, output bit got);
        int n;
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= op;
        src_int <= si;
        src_float <= sf;
        {double_precision_flag, long_integer_flag, conversion_trap_enable} <= md;
        @(posedge mclk);
        op_valid <= 1'b0;
        src_int <= ~si;
        src_float <= ~sf;
        got = 1'b0;
        for (n = 0; n < 300 && !got; n++) begin
            @(negedge mclk);
            got = (res_valid === 1'b1);
        end
    endtask
endmodule // fiec_host_model
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the float/integer/exponent conversion datapath
`default_nettype none
module tb_top
    import fiec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Signals, clock, instances
    // ****************************************************************
    localparam logic [55:0] F1 = 56'h80000000000000; // Fraction .1
    localparam logic [64:0] MA = {65{1'b1}};
    localparam logic [64:0] ME = {1'b0, 8'hFF, 56'h0};
    localparam logic [64:0] ML = 65'h0FFFF;
    localparam logic [64:0] MW = 65'hFFFFFFFF;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        op_valid, double_precision_flag, long_integer_flag, conversion_trap_enable;
    fiec_op_t    op_code;
    logic [31:0] src_int, res_int;
    fiec_float_t src_float, res_float;
    logic        busy, res_valid, zero_condition_flag, conversion_error;
    logic        exp_overflow, exp_underflow, conversion_trap;
    fiec_exc_t   exc_code;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #50 mclk = ~mclk;

    float_int_exponent_convert i_float_int_exponent_convert (.mclk(mclk), .rst_n(rst_n),
        .op_valid(op_valid), .op_code(op_code), .src_int(src_int), .src_float(src_float),
        .double_precision_flag(double_precision_flag), .long_integer_flag(long_integer_flag),
        .conversion_trap_enable(conversion_trap_enable), .busy(busy), .res_valid(res_valid),
        .res_float(res_float), .res_int(res_int), .zero_condition_flag(zero_condition_flag),
        .conversion_error(conversion_error), .exp_overflow(exp_overflow),
        .exp_underflow(exp_underflow), .conversion_trap(conversion_trap), .exc_code(exc_code));

    fiec_host_model i_fiec_host_model (.mclk(mclk), .res_valid(res_valid), .op_valid(op_valid),
        .op_code(op_code), .src_int(src_int), .src_float(src_float),
        .double_precision_flag(double_precision_flag), .long_integer_flag(long_integer_flag),
        .conversion_trap_enable(conversion_trap_enable));

    // ****************************************************************
    // Compare, operation and closing tasks
    // ****************************************************************
    task automatic chk_data(input logic [64:0] got, input logic [64:0] want);
        checks_done++;
        if (got !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: data %h, wanted %h", $time, got, want);
        end
    endtask

    task automatic chk_flags(input logic [7:0] got, input logic [7:0] want);
        checks_done++;
        if (got !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: flags %h, wanted %h", $time, got, want);
        end
    endtask

    // Mask hides result bits that an operation leaves undefined
    task automatic run(input fiec_op_t op, input logic [31:0] si, input fiec_float_t sf,
                       input logic [2:0] md, input logic [64:0] msk, input logic [64:0] want,
                       input logic [7:0] wfl);
        bit got;
        i_fiec_host_model.issue(op, si, sf, md, got);
        chk_flags({6'h0, busy, got}, 8'h01);
        chk_data(((op < store_exponent_op) ? 65'(res_float) : {33'h0, res_int}) & msk, want);
        chk_flags({conversion_error, exp_overflow, exp_underflow, zero_condition_flag,
                   conversion_trap, exc_code}, wfl);
    endtask

    task automatic end_sim;
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard, far above the longest expected run
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ****************************************************************
    // Main sequence, modes are {double, long, trap enable}
    // ****************************************************************
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        run(load_exponent_op, 32'h0000FF80, '0, 3'h0, '0, '0, {5'h04, EXC_EXP_UNF});
        run(load_exponent_op, 32'h0000001C, '0, 3'h0, ME, {1'b0, 8'h9C, 56'h0}, 8'h00);
        run(load_exponent_op, 32'h0000FF81, '0, 3'h0, ME, {1'b0, 8'h01, 56'h0}, 8'h00);
        run(load_exponent_op, 32'h00000081, '0, 3'h0, '0, '0, {5'h08, EXC_EXP_OVF});
        run(load_exponent_op, 32'h00008080, '0, 3'h0, '0, '0, {5'h04, EXC_EXP_UNF});
        run(store_exponent_op, 32'h0, {1'b0, 8'h87, F1}, 3'h0, MW, 65'h7, 8'h00);
        run(store_exponent_op, 32'h0, {1'b0, 8'h22, F1}, 3'h0, MW, 65'hFFA2, 8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h83, F1}, 3'h0, ML, 65'h4, 8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h81, F1}, 3'h0, ML, 65'h1, 8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h83, 56'hF0000000000000}, 3'h4, ML, 65'h7,
            8'h00);
        run(store_integer_op, 32'h0, {1'b1, 8'h83, 56'hF0000000000000}, 3'h0, ML, 65'hFFF9,
            8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h8F, {56{1'b1}}}, 3'h0, ML, 65'h7FFF,
            8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h80, F1}, 3'h0, MW, '0, {5'h12, EXC_CONV_FRAC});
        run(store_integer_op, 32'h0, {1'b0, 8'h91, F1}, 3'h0, MW, '0, {5'h10, EXC_CONV_RNG});
        run(store_integer_op, 32'h0, {1'b0, 8'hA1, F1}, 3'h6, MW, '0, {5'h10, EXC_CONV_RNG});
        run(store_integer_op, 32'h0, {1'b1, 8'h90, F1}, 3'h1, ML, 65'h8000, 8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h90, F1}, 3'h1, '0, '0, {5'h11, EXC_CONV_SIGN});
        run(store_integer_op, 32'h0, {1'b0, 8'hA0, F1}, 3'h6, '0, '0, {5'h10, EXC_CONV_SIGN});
        run(store_integer_op, 32'h0, {1'b0, 8'h9F, F1}, 3'h6, MW, 65'h40000000, 8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h9F, {56{1'b1}}}, 3'h6, MW, 65'h7FFFFFFF,
            8'h00);
        run(store_integer_op, 32'h0, {1'b0, 8'h9F, 56'hFFFFFFFF000000}, 3'h2, MW, 65'h7FFFFF80,
            8'h00);
        run(store_integer_op, 32'h0, {1'b1, 8'h81, F1}, 3'h2, MW, 65'hFFFFFFFF, 8'h00);
        run(load_integer_op, 32'h00000001, '0, 3'h0, MA, {1'b0, 8'h81, F1}, 8'h00);
        run(load_integer_op, 32'h0000FFFF, '0, 3'h0, MA, {1'b1, 8'h81, F1}, 8'h00);
        run(load_integer_op, 32'h00007FFF, '0, 3'h4, MA, {1'b0, 8'h8F, 56'hFFFE0000000000},
            8'h00);
        run(load_integer_op, 32'h00018000, '0, 3'h0, MA, {1'b1, 8'h90, F1}, 8'h00);
        run(load_integer_op, 32'h00010000, '0, 3'h2, MA, {1'b0, 8'h91, F1}, 8'h00);
        run(load_integer_op, 32'h00010000, '0, 3'h0, '0, '0, {5'h02, EXC_NONE});
        run(load_integer_op, 32'h12345678, '0, 3'h6, MA, {1'b0, 8'h9D, 56'h91A2B3C0000000},
            8'h00);
        run(load_integer_op, 32'h12345678, '0, 3'h2, MA, {1'b0, 8'h9D, 56'h91A2B300000000},
            8'h00);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
